// >>> hw/scma_params.svh
`ifndef SCMA_PARAMS_SVH
`define SCMA_PARAMS_SVH
// Address pointer width and implemented byte space
`define SCMA_AW 15
`define SCMA_DEPTH 32
// Register offsets
`define SCMA_A_CFG1 15'h0000
`define SCMA_A_CFG2 15'h0001
`define SCMA_A_LOOP 15'h000E
`define SCMA_A_CFG3 15'h0010
`define SCMA_A_STAT 15'h0011
`define SCMA_A_MB_LO 15'h0014
`define SCMA_A_MB_HI 15'h0015
// Field positions
`define SCMA_B_ASC 5
`define SCMA_B_SHORT 3
`define SCMA_B_PERACC 7
`define SCMA_B_CHK 4
`define SCMA_B_STRICT 5
`define SCMA_B_FAULT 0
// Reset values
`define SCMA_RST_CFG1 8'h00
`define SCMA_RST_CFG2 8'h00
`define SCMA_RST_CFG3 8'h20
// Instruction lengths minus one, checksum seed
`define SCMA_LONG_M1 5'h0F
`define SCMA_SHORT_M1 5'h07
`define SCMA_CRC_SEED 8'hA5
`define SCMA_CRC_POLY 8'h07
`endif

// >>> hw/scma_pkg.sv
package scma_pkg;
	// Frame sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_INSTR = 3'b001,
		ST_WR = 3'b010,
		ST_CHK = 3'b011,
		ST_RD = 3'b100,
		ST_DROP = 3'b101
	} scma_state_t;
	// Interface options decoded from the config bytes
	typedef struct packed {
		logic ascend;
		logic short_ins;
		logic per_access;
		logic strict;
		logic chk_en;
	} scma_cfg_t;
endpackage : scma_pkg

// >>> hw/scma_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin inputs
module scma_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q; // First stage, read only by second
	// Double flop
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_q <= RST;
			q_out <= RST;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule : scma_sync

// >>> hw/scma_regfile.sv
`timescale 1ns/1ns
`include "scma_params.svh"
// Byte-wide configuration memory with option decode
module scma_regfile (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Byte write port
	input wire logic we_in,
	input wire logic [14:0] waddr_in,
	input wire logic [7:0] wdata_in,
	// Paired write for the two-byte register
	input wire logic mb_we_in,
	input wire logic [15:0] mb_data_in,
	// Read port
	input wire logic [14:0] raddr_in,
	output logic [7:0] rdata_out,
	// Side effects
	input wire logic loop_clr_in,
	input wire logic fault_set_in,
	output scma_pkg::scma_cfg_t cfg_out,
	output logic [7:0] loop_out
);
	import scma_pkg::*;
	logic [7:0] mem_q [`SCMA_DEPTH]; // Implemented bytes
	// Only the low space is populated; the rest reads zero
	wire w_hit = we_in && (waddr_in[14:5] == 10'h000);
	wire r_hit = (raddr_in[14:5] == 10'h000);
	wire [4:0] widx = waddr_in[4:0];
	wire [4:0] sidx = 5'(`SCMA_A_STAT);
	wire [4:0] lidx = 5'(`SCMA_A_LOOP);
	assign rdata_out = r_hit ? mem_q[raddr_in[4:0]] : 8'h00;
	assign loop_out = mem_q[lidx];
	assign cfg_out.ascend = mem_q[0][`SCMA_B_ASC];
	assign cfg_out.short_ins = mem_q[1][`SCMA_B_SHORT];
	assign cfg_out.per_access = mem_q[1][`SCMA_B_PERACC];
	assign cfg_out.strict = mem_q[16][`SCMA_B_STRICT];
	assign cfg_out.chk_en = mem_q[16][`SCMA_B_CHK];
	// Storage, status set wins over write-one-to-clear
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < `SCMA_DEPTH; i++) begin
				mem_q[i] <= 8'h00;
			end
			mem_q[0] <= `SCMA_RST_CFG1;
			mem_q[1] <= `SCMA_RST_CFG2;
			mem_q[16] <= `SCMA_RST_CFG3;
		end else begin
			if (w_hit && widx != sidx) begin
				mem_q[widx] <= wdata_in;
			end
			if (mb_we_in) begin
				mem_q[5'(`SCMA_A_MB_LO)] <= mb_data_in[7:0];
				mem_q[5'(`SCMA_A_MB_HI)] <= mb_data_in[15:8];
			end
			// Loop length is one-shot
			if (loop_clr_in) begin
				mem_q[lidx] <= 8'h00;
			end
			// Fault flag
			if (fault_set_in) begin
				mem_q[sidx][`SCMA_B_FAULT] <= 1'b1;
			end else if (w_hit && widx == sidx) begin
				mem_q[sidx] <= mem_q[sidx] & ~wdata_in;
			end
		end
	end
endmodule : scma_regfile

// >>> hw/scma_top.sv
`timescale 1ns/1ns
`include "scma_params.svh"
// Notes on behaviour
// - Nonzero loop length returns pointer to start on writes; reads do not loop
// - Zero loop length: pointer wraps at limits
// - Loop length serves one instruction, then clears
// - Instruction starts at select low, ends
// - First bit: one reads, zero writes
// - Address field 15 bits, 7 when compact
// - Write data sampled on serial clock rise
// - Data phase carries at least one byte
// - Unchecked writes land per byte
// - Checked writes land only on checksum match
// - Mismatch drops rest of frame
// - Write phase output zero unless checksum
// - Read data MSB first, changes on fall
// - Streaming mode after reset
// - Per-access mode: instruction each, pointer holds
// - Direction zero: pointer decrements per byte
// - Decrement past zero rolls to 0x7FFF
// - Direction one: increments, rolls to zero
// - Option bits at fixed register bits
// - Clock idles high, sample on rise
// - Partial multibyte write faults, dropped
module scma_top (
	// System
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	// Serial port pins
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_out
);
	import scma_pkg::*;

	logic [2:0] pin_s; // Synchronised cs, clock, data
	logic sclk_p_q; // Previous clock sample
	scma_state_t state_q, state_d; // Sequencer
	logic [4:0] cnt_q; // Bit counter
	logic [15:0] ins_q; // Instruction shifter
	logic [7:0] sh_q; // Data shifter, both directions
	logic [7:0] pend_q; // Byte awaiting its checksum
	logic [7:0] crc_q; // Checksum being returned
	logic [14:0] ptr_q; // Address pointer
	logic [14:0] start_q; // Instruction start address
	logic [7:0] nb_q; // Bytes written or read since start
	logic [7:0] loop_act_q; // Loop length for this instruction
	logic armed_q; // Loop length written, not yet used
	logic used_q; // Loop length in use
	logic [15:0] stg_q; // Two-byte register staging
	logic [1:0] stg_v_q; // Staged halves
	logic sdo_q; // Output bit
	scma_cfg_t cfg; // Decoded options
	logic [7:0] rdata; // Memory read data
	logic [7:0] loop_val; // Stored loop length

	// Checksum over one byte, CRC-8 with seed
	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] c;
		c = `SCMA_CRC_SEED ^ b;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ `SCMA_CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

	// Pins cross into the system clock; clock and select idle high
	scma_sync #(.W(3), .RST(3'b111)) u_sync (
		.clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.d_in({cs_n_in, sclk_in, sdi_in}),
		.q_out(pin_s)
	);

	// Pin decode and edges
	wire cs_s = pin_s[2];
	wire sclk_s = pin_s[1];
	wire sdi_s = pin_s[0];
	wire rise_w = sclk_s && !sclk_p_q;
	wire fall_w = !sclk_s && sclk_p_q;
	wire data_st = (state_q == ST_WR) || (state_q == ST_CHK) || (state_q == ST_RD);
	wire byte_done_w = data_st && rise_w && (cnt_q[2:0] == 3'h7);
	wire frame_end_w = cs_s && (state_q != ST_IDLE);

	// Instruction decode
	wire [4:0] ins_m1 = cfg.short_ins ? `SCMA_SHORT_M1 : `SCMA_LONG_M1;
	wire ins_done_w = (state_q == ST_INSTR) && !cs_s && rise_w && (cnt_q == ins_m1);
	wire [15:0] ins_w = {ins_q[14:0], sdi_s};
	wire ins_rd_w = cfg.short_ins ? ins_w[7] : ins_w[15];
	wire [14:0] dec_addr_w = cfg.short_ins ? {8'h00, ins_w[6:0]} : ins_w[14:0];

	// Write data and checksum
	wire [7:0] rx_w = {sh_q[6:0], sdi_s};
	wire chk_ok_w = (rx_w == crc8(pend_q));
	wire wr_commit_w = ((state_q == ST_WR) && byte_done_w && !cfg.chk_en)
		|| ((state_q == ST_CHK) && byte_done_w && chk_ok_w);
	wire [7:0] wbyte_w = cfg.chk_en ? pend_q : rx_w;
	wire bad_chk_w = (state_q == ST_CHK) && byte_done_w && !chk_ok_w;

	// Pointer step; 15-bit arithmetic gives both fixed rollovers
	wire is_wr_w = (state_q == ST_WR) || (state_q == ST_CHK);
	wire loop_hit_w = is_wr_w && (loop_act_q != 8'h00) && (nb_q + 8'h01 == loop_act_q);
	wire [14:0] step_w = cfg.ascend ? ptr_q + 15'h0001 : ptr_q - 15'h0001;
	wire [14:0] nxt_ptr_w = loop_hit_w ? start_q : step_w;
	wire advance_w = !cfg.per_access && (wr_commit_w || ((state_q == ST_RD) && byte_done_w));
	wire [14:0] rd_addr_w = (state_q == ST_INSTR) ? dec_addr_w : nxt_ptr_w;

	// Two-byte register handling under strict access
	wire is_mb_w = cfg.strict && ((ptr_q == `SCMA_A_MB_LO) || (ptr_q == `SCMA_A_MB_HI));
	wire mb_half_w = (ptr_q == `SCMA_A_MB_HI);
	wire [15:0] stg_w = mb_half_w ? {wbyte_w, stg_q[7:0]} : {stg_q[15:8], wbyte_w};
	wire [1:0] stg_v_w = stg_v_q | (mb_half_w ? 2'b10 : 2'b01);
	wire mb_we_w = wr_commit_w && is_mb_w && (stg_v_w == 2'b11);
	wire we_w = wr_commit_w && !is_mb_w;
	wire fault_w = frame_end_w && (stg_v_q != 2'b00);

	// Instruction end for the one-shot loop length
	wire instr_end_w = data_st || (state_q == ST_DROP) ? (cs_s || state_d == ST_INSTR) : 1'b0;
	wire loop_clr_w = instr_end_w && used_q;
	wire loop_wr_w = we_w && (ptr_q == `SCMA_A_LOOP);

	// Next state
	always_comb begin
		state_d = state_q;
		if (cs_s) begin
			state_d = ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_d = ST_INSTR;
				end
				ST_INSTR: begin
					if (ins_done_w) begin
						state_d = ins_rd_w ? ST_RD : ST_WR;
					end
				end
				ST_WR: begin
					if (byte_done_w && cfg.chk_en) begin
						state_d = ST_CHK;
					end else if (byte_done_w && cfg.per_access) begin
						state_d = ST_INSTR;
					end
				end
				ST_CHK: begin
					if (bad_chk_w) begin
						state_d = ST_DROP;
					end else if (byte_done_w) begin
						state_d = cfg.per_access ? ST_INSTR : ST_WR;
					end
				end
				ST_RD: begin
					if (byte_done_w && cfg.per_access) begin
						state_d = ST_INSTR;
					end
				end
				ST_DROP: begin
					state_d = ST_DROP;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer and clock edge history
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= ST_IDLE;
			sclk_p_q <= 1'b1;
		end else begin
			state_q <= state_d;
			sclk_p_q <= sclk_s;
		end
	end

	// Bit counter and instruction shifter
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q <= 5'h00;
			ins_q <= 16'h0000;
		end else if (state_q == ST_IDLE || ins_done_w || state_d == ST_INSTR && data_st) begin
			cnt_q <= 5'h00; // Each phase counts from zero
		end else if (rise_w) begin
			cnt_q <= cnt_q + 5'h01;
			ins_q <= ins_w;
		end
	end

	// Data shifter: for reads loads on the rise ending a byte and shifts on fall; fills on rise for writes
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sh_q <= 8'h00;
		end else if (ins_done_w || ((state_q == ST_RD) && byte_done_w)) begin
			sh_q <= rdata;
		end else if ((state_q == ST_RD) && fall_w) begin
			sh_q <= {sh_q[6:0], 1'b0};
		end else if (is_wr_w && rise_w) begin
			sh_q <= rx_w;
		end
	end

	// Checksum byte held and returned while the host sends its own
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pend_q <= 8'h00;
			crc_q <= 8'h00;
		end else if ((state_q == ST_WR) && byte_done_w) begin
			pend_q <= rx_w;
			crc_q <= crc8(rx_w);
		end else if ((state_q == ST_CHK) && fall_w) begin
			crc_q <= {crc_q[6:0], 1'b0};
		end
	end

	// Output bit; zero unless reading or returning a checksum
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sdo_q <= 1'b0;
		end else if (cs_s) begin
			sdo_q <= 1'b0;
		end else if (fall_w) begin
			sdo_q <= (state_q == ST_RD) ? sh_q[7]
				: (state_q == ST_CHK) ? crc_q[7] : 1'b0;
		end
	end

	// Address pointer, start address and byte count
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ptr_q <= 15'h0000;
			start_q <= 15'h0000;
			nb_q <= 8'h00;
		end else if (ins_done_w) begin
			ptr_q <= dec_addr_w;
			start_q <= dec_addr_w;
			nb_q <= 8'h00;
		end else if (advance_w) begin
			ptr_q <= nxt_ptr_w;
			nb_q <= loop_hit_w ? 8'h00 : nb_q + 8'h01;
		end
	end

	// One-shot loop length: armed by a write, taken by the next instruction
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			armed_q <= 1'b0;
			used_q <= 1'b0;
			loop_act_q <= 8'h00;
		end else begin
			if (ins_done_w) begin
				loop_act_q <= armed_q ? loop_val : 8'h00;
				used_q <= armed_q;
			end else if (loop_clr_w) begin
				used_q <= 1'b0;
			end
			if (loop_wr_w) begin
				armed_q <= 1'b1;
			end else if (ins_done_w) begin
				armed_q <= 1'b0;
			end
		end
	end

	// Staging; a half left over at frame end is discarded
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stg_q <= 16'h0000;
			stg_v_q <= 2'b00;
		end else if (frame_end_w || mb_we_w) begin
			stg_v_q <= 2'b00;
		end else if (wr_commit_w && is_mb_w) begin
			stg_q <= stg_w;
			stg_v_q <= stg_v_w;
		end
	end

	// Configuration memory
	scma_regfile u_regs (
		.clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.we_in(we_w),
		.waddr_in(ptr_q),
		.wdata_in(wbyte_w),
		.mb_we_in(mb_we_w),
		.mb_data_in(stg_w),
		.raddr_in(rd_addr_w),
		.rdata_out(rdata),
		.loop_clr_in(loop_clr_w),
		.fault_set_in(fault_w),
		.cfg_out(cfg),
		.loop_out(loop_val)
	);

	assign sdo_out = sdo_q;
	assign sdo_oe_out = !cs_s; // Drive only inside a frame

	// Checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	a_frame_start: assert property ((state_q == ST_IDLE && !cs_s) |=> state_q == ST_INSTR)
		else $error("instruction phase did not start");
	a_frame_stop: assert property (cs_s |=> state_q == ST_IDLE)
		else $error("frame not closed on select high");
	a_cmd_read: assert property (ins_done_w && ins_rd_w |=> state_q == ST_RD)
		else $error("read command not decoded");
	a_instr_len: assert property (ins_done_w |-> cnt_q == (cfg.short_ins ? 5'd7 : 5'd15))
		else $error("instruction length wrong");
	// Last checksum bit may stand into the write byte until its first fall
	a_wr_sdo_zero: assert property (state_q == ST_WR && fall_w && !cs_s |=> !sdo_q)
		else $error("output not zero in write phase");
	a_rd_msb: assert property (state_q == ST_RD && fall_w && !cs_s |=> sdo_q == $past(sh_q[7]))
		else $error("read bit order wrong");
	a_dec_wrap: assert property (advance_w && !loop_hit_w && !cfg.ascend && ptr_q == 15'h0000
		|=> ptr_q == 15'h7FFF)
		else $error("decrement rollover wrong");
	a_inc_step: assert property (advance_w && !loop_hit_w && cfg.ascend
		|=> ptr_q == $past(ptr_q) + 15'h0001)
		else $error("increment step wrong");
	a_loop_back: assert property (advance_w && loop_hit_w |=> ptr_q == start_q)
		else $error("loop did not return to start");
	a_chk_drop: assert property (bad_chk_w && !cs_s |=> state_q == ST_DROP ##1 !we_w)
		else $error("mismatch did not drop frame");
	a_peracc_hold: assert property (cfg.per_access && byte_done_w |=> ptr_q == $past(ptr_q))
		else $error("pointer moved in per-access mode");
endmodule : scma_top

// >>> verification/scma_host.sv
`timescale 1ns/1ns
// Host side of the serial port, mode 3 master
module scma_host (
	// System clock
	input wire logic sys_clk_in,
	// Serial pins
	output logic cs_n_out,
	output logic sclk_out,
	output logic sdi_out,
	input wire logic sdo_in,
	// Byte seen on the return line
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out
);
	// Idle: deselected, clock parked high
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
		sdi_out = 1'b1;
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
	end
	// Wait n system clock falls
	task automatic tk(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : tk
	// One bit: drive on fall, sample late in high phase
	task automatic bit_x(input logic b, output logic r);
		tk(1);
		sclk_out = 1'b0;
		sdi_out = b;
		tk(4);
		sclk_out = 1'b1;
		tk(3);
		r = sdo_in; // Settled long after the device update
	endtask : bit_x
	// Open a frame
	task automatic start();
		cs_n_out = 1'b0;
		tk(4);
	endtask : start
	// Close a frame; released line shows the inverse, not the last bit
	task automatic stop();
		tk(4);
		cs_n_out = 1'b1;
		sdi_out = ~sdi_out;
		tk(12);
	endtask : stop
	// Command bit then address, MSB first
	task automatic instr(input logic rd, input logic [14:0] a, input logic sh);
		logic r;
		bit_x(rd, r);
		for (int i = sh ? 6 : 14; i >= 0; i--) bit_x(a[i], r);
	endtask : instr
	// One data byte each way, reported as a one-cycle pulse
	task automatic byte_x(input logic [7:0] d);
		logic [7:0] q;
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
			q[i] = r;
		end
		rx_byte_out = q;
		rx_valid_out = 1'b1;
		tk(1);
		rx_valid_out = 1'b0;
	endtask : byte_x
endmodule : scma_host

// >>> verification/tb.sv
`timescale 1ns/1ns
`include "scma_params.svh"
// Self-checking bench for the config access block
module tb;
	import scma_pkg::*;
	logic sys_clk_in;
	logic resetn_in;
	logic cs_n, sclk, sdi, sdo, sdo_oe, rx_valid;
	logic [7:0] rx_byte;
	logic sh; // Compact address in use
	logic [8:0] note; // Bit 8 marks a byte worth comparing
	logic [8:0] exp_q[$]; // Expected return bytes, oldest first
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Design under test
	scma_top dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n),
		.sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe));
	// Far-side host
	scma_host host (.sys_clk_in(sys_clk_in), .cs_n_out(cs_n), .sclk_out(sclk),
		.sdi_out(sdi), .sdo_in(sdo), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));
	// 25 MHz clock
	initial begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	// Compare and count
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Verdict and end of run
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	// Watcher: oldest note against each returned byte; also the hang limit
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			error_cnt++;
			finish_test();
		end
		if (rx_valid === 1'b1) begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
			if (note[8]) check("sdo_byte", rx_byte, note[7:0]);
		end
	end
	// Checksum of one byte, MSB-first shift
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = `SCMA_CRC_SEED ^ d;
		for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ `SCMA_CRC_POLY : {c[6:0], 1'b0};
		return c;
	endfunction : crc8
	// Write instruction inside an open frame; return line must stay low
	task automatic xw(input logic [14:0] a, input logic [7:0] d[$]);
		host.instr(1'b0, a, sh);
		foreach (d[i]) begin
			exp_q.push_back({1'b1, 8'h00});
			host.byte_x(d[i]);
		end
	endtask : xw
	// Read instruction inside an open frame
	task automatic xr(input logic [14:0] a, input logic [7:0] e[$]);
		host.instr(1'b1, a, sh);
		foreach (e[i]) begin
			exp_q.push_back({1'b1, e[i]});
			host.byte_x(8'hff);
		end
	endtask : xr
	// Whole frames, one instruction each
	task automatic wr(input logic [14:0] a, input logic [7:0] d[$]);
		host.start();
		xw(a, d);
		host.stop();
	endtask : wr
	task automatic rd(input logic [14:0] a, input logic [7:0] e[$]);
		host.start();
		xr(a, e);
		host.stop();
	endtask : rd
	// Checked write byte: data then checksum, device echoes its own sum
	task automatic cw(input logic [7:0] d, input logic ok, input logic care);
		exp_q.push_back({care, 8'h00});
		host.byte_x(d);
		exp_q.push_back({care, crc8(d)});
		host.byte_x(ok ? crc8(d) : ~crc8(d));
	endtask : cw
	// Main sequence
	initial begin
		logic [7:0] a, b, c;
		logic r;
		resetn_in = 1'b0;
		sh = 1'b0;
		void'($urandom(32'hae1a_3b67));
		a = 8'($urandom);
		b = 8'($urandom);
		c = 8'($urandom) | 8'h01;
		repeat (12) @(negedge sys_clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		check("oe_idle", {7'h00, sdo_oe}, 8'h00);
		// Reset values, descending stream read
		rd(`SCMA_A_CFG2, '{`SCMA_RST_CFG2, `SCMA_RST_CFG1});
		rd(`SCMA_A_CFG3, '{`SCMA_RST_CFG3});
		// Random descending stream write and readback
		wr(15'h0005, '{a, b, c});
		rd(15'h0005, '{a, b, c});
		// Decrement past zero must reach 0x7FFF, not the top of memory
		wr(15'h001f, '{c});
		rd(15'h0000, '{8'h00, 8'h00});
		// Ascending pointer and its rollover
		wr(`SCMA_A_CFG1, '{8'h20});
		rd(15'h7fff, '{8'h00, 8'h20});
		wr(15'h0006, '{b, a});
		rd(15'h0005, '{a, b, a});
		wr(`SCMA_A_CFG1, '{8'h00});
		// Compact address instructions
		wr(`SCMA_A_CFG2, '{8'h08});
		sh = 1'b1;
		wr(15'h0007, '{c});
		rd(15'h0007, '{c});
		wr(`SCMA_A_CFG2, '{8'h00});
		sh = 1'b0;
		rd(15'h0007, '{c});
		// Per-access mode: one instruction per byte, pointer held
		wr(`SCMA_A_CFG2, '{8'h80});
		host.start();
		xw(15'h0008, '{a});
		xw(15'h000a, '{b});
		xr(15'h0008, '{a});
		xw(`SCMA_A_CFG2, '{8'h00});
		host.stop();
		rd(15'h000a, '{b, 8'h00, a});
		// One-shot loop length of two bytes
		wr(`SCMA_A_LOOP, '{8'h02});
		wr(15'h000d, '{a, b, c});
		rd(`SCMA_A_LOOP, '{8'h00, c, b, 8'h00});
		// Checksum gating; a bad sum drops the rest of the frame
		wr(`SCMA_A_CFG3, '{8'h30});
		host.start();
		host.instr(1'b0, 15'h000b, sh);
		cw(a, 1'b1, 1'b1);
		cw(b ^ 8'hff, 1'b0, 1'b1);
		cw(c, 1'b1, 1'b0);
		host.stop();
		host.start();
		host.instr(1'b0, `SCMA_A_CFG3, sh);
		cw(8'h20, 1'b1, 1'b1);
		host.stop();
		rd(15'h000b, '{a, b, 8'h00});
		// Partial write of the two-byte register faults and is dropped
		wr(`SCMA_A_MB_LO, '{a});
		rd(`SCMA_A_STAT, '{8'h01});
		rd(`SCMA_A_MB_HI, '{8'h00, 8'h00});
		wr(`SCMA_A_STAT, '{8'h01});
		rd(`SCMA_A_STAT, '{8'h00});
		wr(`SCMA_A_MB_HI, '{b, a});
		rd(`SCMA_A_MB_HI, '{b, a});
		// Select released mid-instruction, then mid-byte
		host.start();
		check("oe_frame", {7'h00, sdo_oe}, 8'h01);
		for (int i = 0; i < 9; i++) host.bit_x(1'b0, r);
		host.stop();
		host.start();
		host.instr(1'b0, 15'h0003, sh);
		for (int i = 0; i < 5; i++) host.bit_x(1'b0, r);
		host.stop();
		rd(15'h0003, '{c});
		repeat (20) @(negedge sys_clk_in);
		check("notes_left", 8'(exp_q.size()), 8'h00);
		finish_test();
	end
endmodule : tb
